/* File: include/icm_params.svh */
`ifndef ICM_PARAMS_SVH
`define ICM_PARAMS_SVH

// fixed upper six bits of the 7-bit slave address
`define ICM_DEV_HI   6'h28
// reserved register windows, writes refused
`define ICM_RSV_LO   8'h58
`define ICM_RSV_HI   8'h7f
`define ICM_TOP      8'hab
// configuration bytes recalled at power-up
`define ICM_CFG_LAST 8'h57
// bit count positions
`define ICM_BYTE_END 4'h8
`define ICM_TX_LAST  4'h7
// reset values
`define ICM_ADDR_RST 8'h00
`define ICM_PIN_RST  3'h7
`endif

/* File: include/icm_pkg.sv */
package icm_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX   = 5'h02,
      ST_ACK  = 5'h04,
      ST_TX   = 5'h08,
      ST_MACK = 5'h10
   } icm_state_t;
endpackage

/* File: hw/icm_sync.sv */
`timescale 1ns/100ps
module icm_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // pins and filtered levels
   input  wire logic [W-1:0] d_in,
   output logic [W-1:0]      d_out
);
   logic [W-1:0] ff1_q;
   logic [W-1:0] ff2_q;
   logic [W-1:0] ff3_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ff1_q <= RST;
         ff2_q <= RST;
         ff3_q <= RST;
      end else begin
         ff1_q <= d_in;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
      end
   end

   // a level counts only once two stages agree; filters single glitches
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         d_out <= RST;
      end else begin
         d_out <= (ff2_q & ~(ff2_q ^ ff3_q)) | (d_out & (ff2_q ^ ff3_q));
      end
   end
endmodule

/* File: hw/icm_slave.sv */
`timescale 1ns/100ps
`include "icm_params.svh"
module icm_slave #(
   parameter int         AW       = 8,
   parameter logic [7:0] CFG_LAST = `ICM_CFG_LAST
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // serial bus pins
   input  wire logic          serial_clk_in,
   input  wire logic          serial_data_in,
   output logic               serial_data_out,
   output logic               serial_data_oe,
   input  wire logic          addr_select,
   // memory steering from device logic
   input  wire logic          nonvolatile_access_select,
   input  wire logic          write_protect,
   // error status
   output logic               ecc_used,
   output logic               ecc_fail,
   // recall status
   output logic               op_enable,
   output logic               recall_fault,
   // shadow configuration read port
   input  wire logic [AW-1:0] cfg_addr,
   output logic [7:0]         cfg_data,
   // bus state
   output icm_pkg::icm_state_t bus_state
);
   import icm_pkg::*;

   localparam int DEPTH = 1 << AW;

   function automatic logic [12:0] icm_enc(input logic [7:0] d);
      logic [3:0] p;
      p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
      return {^{p, d}, p, d};
   endfunction

   // returns {fail, used, data}
   function automatic logic [9:0] icm_dec(input logic [12:0] w);
      logic [12:0] e;
      logic [3:0]  s;
      logic [7:0]  c;
      logic        ov;
      e  = icm_enc(w[7:0]);
      s  = e[11:8] ^ w[11:8];
      ov = ^w;
      c  = w[7:0];
      case (s)
         4'h3: c[0] = ~c[0];
         4'h5: c[1] = ~c[1];
         4'h6: c[2] = ~c[2];
         4'h7: c[3] = ~c[3];
         4'h9: c[4] = ~c[4];
         4'ha: c[5] = ~c[5];
         4'hb: c[6] = ~c[6];
         4'hc: c[7] = ~c[7];
         default: c = w[7:0];
      endcase
      return {~ov & (s != 4'h0), ov, ov ? c : w[7:0]};
   endfunction

   logic [7:0]    shadow_mem [DEPTH];
   logic [12:0]   nv_mem     [DEPTH];

   logic [2:0]    pins_s;
   logic          scl_s;
   logic          sda_s;
   logic          sel_s;
   logic          scl_p_q;
   logic          sda_p_q;
   icm_state_t    state_q;
   logic [3:0]    cnt_q;
   logic [7:0]    sh_q;
   logic [7:0]    tx_q;
   logic          first_q;
   logic          word_q;
   logic          rw_q;
   logic          mack_q;
   logic [AW-1:0] addr_q;
   logic          oe_q;
   logic          rec_busy_q;
   logic [AW-1:0] rec_addr_q;

   logic          scl_rise;
   logic          scl_fall;
   logic          start_e;
   logic          stop_e;
   logic          byte_end;
   logic          dev_match;
   logic          prot;
   logic          acc_dev;
   logic          acc_word;
   logic          acc_data;
   logic          ack_end;
   logic          tx_load;
   logic [AW-1:0] dec_addr;
   logic [9:0]    dec;
   logic [7:0]    rd_byte;

   // pins cross into core_clk; bus idles high
   icm_sync #(
      .W   (3),
      .RST (`ICM_PIN_RST)
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d_in     ({serial_clk_in, serial_data_in, addr_select}),
      .d_out    (pins_s)
   );

   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign sel_s = pins_s[0];

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_e  = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_e   = scl_s & scl_p_q & ~sda_p_q & sda_s;

   assign byte_end  = (state_q == ST_RX) && scl_fall
                      && (cnt_q == `ICM_BYTE_END);
   assign dev_match = (sh_q[7:1] == {`ICM_DEV_HI, sel_s});
   assign prot      = write_protect
                      || (addr_q >= `ICM_RSV_LO && addr_q <= `ICM_RSV_HI)
                      || (addr_q > `ICM_TOP);
   assign acc_dev   = byte_end && first_q && dev_match;
   assign acc_word  = byte_end && !first_q && word_q;
   assign acc_data  = byte_end && !first_q && !word_q && !prot;
   assign ack_end   = (state_q == ST_ACK) && scl_fall;
   assign tx_load   = (ack_end && rw_q)
                      || ((state_q == ST_MACK) && scl_fall && mack_q);

   assign dec_addr = rec_busy_q ? rec_addr_q : addr_q;
   assign dec      = icm_dec(nv_mem[dec_addr]);
   assign rd_byte  = nonvolatile_access_select ? dec[7:0]
                                                : shadow_mem[addr_q];

   // slave only, fsm follows master clock
   always_ff @(posedge core_clk) begin
      if (!rst_n || rec_busy_q) begin
         state_q <= ST_IDLE;
      end else if (start_e) begin
         state_q <= ST_RX;
      end else if (stop_e) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: state_q <= ST_IDLE;
            ST_RX: begin
               if (byte_end) begin
                  state_q <= (acc_dev || acc_word || acc_data)
                             ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_q <= rw_q ? ST_TX : ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall && cnt_q == `ICM_TX_LAST) begin
                  state_q <= ST_MACK;
               end
            end
            ST_MACK: begin
               if (scl_fall) begin
                  state_q <= mack_q ? ST_TX : ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || start_e || ack_end || tx_load) begin
         cnt_q <= 4'h0;
      end else if ((state_q == ST_RX && scl_rise)
                   || (state_q == ST_TX && scl_fall)) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
         tx_q <= 8'h00;
      end else begin
         if (state_q == ST_RX && scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
         end
         if (tx_load) begin
            tx_q <= rd_byte;
         end else if (state_q == ST_TX && scl_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         first_q <= 1'b0;
         word_q  <= 1'b0;
         rw_q    <= 1'b0;
      end else if (start_e) begin
         first_q <= 1'b1;
      end else if (acc_dev) begin
         first_q <= 1'b0;
         rw_q    <= sh_q[0];
         word_q  <= ~sh_q[0];
      end else if (acc_word) begin
         word_q  <= 1'b0;
      end
   end

   // master ack sampled on ninth rising clock
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mack_q <= 1'b0;
      end else if (state_q == ST_MACK && scl_rise) begin
         mack_q <= ~sda_s;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_q <= `ICM_ADDR_RST;
      end else if (acc_word) begin
         addr_q <= sh_q[AW-1:0];
      end else if (acc_data) begin
         addr_q <= {addr_q[AW-1:2], addr_q[1:0] + 2'h1};
      end else if (tx_load) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // ack and data drive low only
   always_ff @(posedge core_clk) begin
      if (!rst_n || start_e || stop_e) begin
         oe_q <= 1'b0;
      end else if (byte_end) begin
         oe_q <= acc_dev || acc_word || acc_data;
      end else if (tx_load) begin
         oe_q <= ~rd_byte[7];
      end else if (ack_end) begin
         oe_q <= 1'b0;
      end else if (state_q == ST_TX && scl_fall) begin
         oe_q <= (cnt_q == `ICM_TX_LAST) ? 1'b0 : ~tx_q[6];
      end else if (state_q == ST_MACK && scl_fall) begin
         oe_q <= 1'b0;
      end
   end

   assign serial_data_out = 1'b0;
   assign serial_data_oe  = oe_q;
   assign bus_state       = state_q;

   // nonvolatile contents survive reset, so no reset branch
   // plain always: the array may be preloaded from outside at startup
   always @(posedge core_clk) begin
      if (acc_data && nonvolatile_access_select) begin
         nv_mem[addr_q] <= icm_enc(sh_q);
      end
   end

   // keep old byte on double error
   always_ff @(posedge core_clk) begin
      if (rst_n && rec_busy_q && !dec[9]) begin
         shadow_mem[rec_addr_q] <= dec[7:0];
      end else if (acc_data && !nonvolatile_access_select) begin
         shadow_mem[addr_q] <= sh_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rec_busy_q <= 1'b1;
         rec_addr_q <= '0;
      end else if (rec_busy_q) begin
         rec_addr_q <= rec_addr_q + 1'b1;
         if (rec_addr_q == CFG_LAST[AW-1:0]) begin
            rec_busy_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         recall_fault <= 1'b0;
         op_enable    <= 1'b0;
      end else if (rec_busy_q) begin
         recall_fault <= recall_fault | dec[9];
         op_enable    <= 1'b0;
      end else begin
         op_enable    <= ~recall_fault;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ecc_used <= 1'b0;
         ecc_fail <= 1'b0;
      end else if (rec_busy_q || (tx_load && nonvolatile_access_select)) begin
         ecc_used <= dec[8] & ~dec[9];
         ecc_fail <= dec[9];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_data <= 8'h00;
      end else begin
         cfg_data <= shadow_mem[cfg_addr];
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

chk_nack_mismatch:
   assert property (byte_end && first_q && !dev_match && !start_e
                    && !stop_e |=> !oe_q && state_q == ST_IDLE)
   else $error("mismatched slave byte was acknowledged");

chk_ack_held:
   assert property (state_q == ST_ACK && !start_e && !stop_e |-> oe_q)
   else $error("ack not driven during ninth clock");

chk_idle_quiet:
   assert property (state_q == ST_IDLE && !$past(tx_load) |-> !oe_q)
   else $error("bus driven while idle");

chk_change_low:
   assert property ($changed(oe_q) && !$past(start_e) && !$past(stop_e)
                    |-> !scl_p_q)
   else $error("data changed while clock high");

chk_msb_first:
   assert property (tx_load && !start_e && !stop_e
                    |=> oe_q == ~tx_q[7])
   else $error("first bit out is not bit 7");

chk_ecc_clean:
   assert property (tx_load && nonvolatile_access_select && !rec_busy_q
                    && dec[9:8] == 2'b00 |=> !ecc_used && !ecc_fail)
   else $error("flags not cleared on clean read");

chk_ecc_fail:
   assert property (tx_load && nonvolatile_access_select && dec[9]
                    |=> ecc_fail && !ecc_used)
   else $error("uncorrectable read not flagged");

chk_page_wrap:
   assert property (acc_data |=> addr_q[AW-1:2] == $past(addr_q[AW-1:2])
                    && addr_q[1:0] == $past(addr_q[1:0]) + 2'h1)
   else $error("page write left its page");

chk_recall_gate:
   assert property (rec_busy_q |=> !op_enable && state_q == ST_IDLE)
   else $error("operation enabled during recall");

chk_prot_nack:
   assert property (byte_end && !first_q && !word_q && prot
                    && !start_e && !stop_e |=> !oe_q)
   else $error("protected write was acknowledged");
endmodule

/* File: test/icm_mstr.sv */
`timescale 1ns/100ps
module icm_mstr #(
   parameter int HP = 125
) (
   // clock
   input  wire logic core_clk,
   // wire level
   input  wire logic sda,
   // bus drive
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // slow clock, data moves while low
   task automatic bit_io(input logic b, output logic r);
      wt(HP / 2);
      sda_low <= ~b;
      wt(HP - HP / 2);
      scl <= 1'b1;
      wt(HP);
      r = sda;
      scl <= 1'b0;
   endtask

   task automatic start();
      wt(HP / 2);
      sda_low <= 1'b0;
      wt(HP - HP / 2);
      scl <= 1'b1;
      wt(HP);
      sda_low <= 1'b1;
      wt(HP);
      scl <= 1'b0;
   endtask

   // stop once the line is back with us
   task automatic stop();
      wt(HP / 2);
      sda_low <= 1'b1;
      wt(HP - HP / 2);
      scl <= 1'b1;
      wt(HP);
      sda_low <= 1'b0;
      wt(HP);
   endtask

   // clock low from idle, no start
   task automatic park();
      scl <= 1'b0;
      wt(HP);
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic acked);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(ack_in, r);
      acked = ~r;
   endtask
endmodule

/* File: test/test_i2c_config_memory_slave.sv */
`timescale 1ns/100ps
module test_i2c_config_memory_slave;
   import icm_pkg::*;
   logic       core_clk;
   logic       rst_n;
   logic       scl;
   logic       sda_low;
   logic       serial_data_out;
   logic       serial_data_oe;
   logic       addr_select;
   logic       nonvolatile_access_select;
   logic       write_protect;
   logic       ecc_used;
   logic       ecc_fail;
   logic       op_enable;
   logic       recall_fault;
   logic [7:0] cfg_addr;
   logic [7:0] cfg_data;
   icm_state_t bus_state;
   wire        sda;
   int         n_errors;
   int         num_checks;

   // both ends open drain, pulled up
   assign sda = ~(sda_low | (serial_data_oe & ~serial_data_out));

   // short recall keeps the run brief
   icm_slave #(.CFG_LAST(8'h03)) icm_slave_i (
      .core_clk(core_clk), .rst_n(rst_n),
      .serial_clk_in(scl), .serial_data_in(sda),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .addr_select(addr_select),
      .nonvolatile_access_select(nonvolatile_access_select),
      .write_protect(write_protect),
      .ecc_used(ecc_used), .ecc_fail(ecc_fail),
      .op_enable(op_enable), .recall_fault(recall_fault),
      .cfg_addr(cfg_addr), .cfg_data(cfg_data), .bus_state(bus_state)
   );

   icm_mstr #(.HP(125)) icm_mstr_i (
      .core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [12:0] cw(input logic [7:0] d);
      logic [3:0] p;
      p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
      return {^{p, d}, p, d};
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic       a;
      icm_mstr_i.byte_io(b, 1'b1, rx, a);
      chk({7'h00, a}, {7'h00, exp_ack});
   endtask

   task automatic recv(input logic more, input logic [7:0] exp);
      logic [7:0] rx;
      logic       a;
      icm_mstr_i.byte_io(8'hff, ~more, rx, a);
      chk(rx, exp);
   endtask

   task automatic cfg_chk(input logic [7:0] a, input logic [7:0] e);
      cfg_addr <= a;
      repeat (3) @(posedge core_clk);
      chk(cfg_data, e);
   endtask

   task automatic t_recall();
      for (int i = 0; i < 300 && op_enable !== 1'b1; i++)
         @(posedge core_clk);
      chk({6'h00, op_enable, recall_fault}, 8'h02);
      for (int i = 0; i < 4; i++)
         cfg_chk(8'(i), 8'(i) ^ 8'h5a);
   endtask

   task automatic t_ignore();
      icm_mstr_i.park();
      send(8'ha0, 1'b0);
      chk({3'h0, bus_state}, {3'h0, ST_IDLE});
      icm_mstr_i.stop();
   endtask

   task automatic t_page();
      nonvolatile_access_select <= 1'b0;
      icm_mstr_i.start();
      send(8'ha0, 1'b1);
      send(8'h06, 1'b1);
      for (int k = 0; k < 4; k++)
         send(8'ha0 + 8'(k), 1'b1);
      icm_mstr_i.stop();
      icm_mstr_i.start();
      send(8'ha0, 1'b1);
      send(8'h04, 1'b1);
      icm_mstr_i.start();
      send(8'ha1, 1'b1);
      recv(1'b1, 8'ha2);
      recv(1'b1, 8'ha3);
      recv(1'b1, 8'ha0);
      recv(1'b0, 8'ha1);
      icm_mstr_i.stop();
      cfg_chk(8'h04, 8'ha2);
   endtask

   task automatic t_refuse();
      addr_select <= 1'b1;
      icm_mstr_i.start();
      send(8'ha0, 1'b0);
      icm_mstr_i.stop();
      icm_mstr_i.start();
      send(8'ha2, 1'b1);
      send(8'h60, 1'b1);
      send(8'h33, 1'b0);
      icm_mstr_i.stop();
      write_protect <= 1'b1;
      icm_mstr_i.start();
      send(8'ha2, 1'b1);
      send(8'h08, 1'b1);
      send(8'h44, 1'b0);
      icm_mstr_i.stop();
      write_protect <= 1'b0;
   endtask

   task automatic t_nv();
      logic [7:0] rx;
      logic       a;
      nonvolatile_access_select <= 1'b1;
      icm_mstr_i.start();
      send(8'ha2, 1'b1);
      send(8'h10, 1'b1);
      icm_mstr_i.start();
      send(8'ha3, 1'b1);
      recv(1'b0, 8'h4a);
      icm_mstr_i.stop();
      chk({6'h00, ecc_used, ecc_fail}, 8'h02);
      icm_mstr_i.start();
      send(8'ha3, 1'b1);
      icm_mstr_i.byte_io(8'hff, 1'b1, rx, a);
      icm_mstr_i.stop();
      chk({6'h00, ecc_used, ecc_fail}, 8'h01);
      icm_mstr_i.start();
      send(8'ha3, 1'b1);
      recv(1'b0, 8'h48);
      icm_mstr_i.stop();
      chk({6'h00, ecc_used, ecc_fail}, 8'h00);
   endtask

   task automatic t_fault();
      icm_slave_i.nv_mem[2] = cw(8'h58) ^ 13'h0030;
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 100 && recall_fault !== 1'b1; i++)
         @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk({6'h00, op_enable, recall_fault}, 8'h01);
      cfg_chk(8'h02, 8'h58);
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      rst_n                     = 1'b0;
      addr_select               = 1'b0;
      nonvolatile_access_select = 1'b0;
      write_protect             = 1'b0;
      cfg_addr                  = 8'h00;
      n_errors                  = 0;
      num_checks                = 0;
      for (int i = 0; i < 256; i++)
         icm_slave_i.nv_mem[i] = cw(8'(i) ^ 8'h5a);
      // one flipped bit in words 1 and 16, then two flipped bits in word 17
      icm_slave_i.nv_mem[1]  = cw(8'h5b) ^ 13'h0004;
      icm_slave_i.nv_mem[16] = cw(8'h4a) ^ 13'h0001;
      icm_slave_i.nv_mem[17] = cw(8'h4b) ^ 13'h0003;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_recall();
      t_ignore();
      t_page();
      t_refuse();
      t_nv();
      t_fault();
      conclude();
   end

   // run needs roughly 73k cycles
   initial begin
      repeat (95000) @(posedge core_clk);
      n_errors++;
      conclude();
   end
endmodule
